// ===== current_input_fault_selector.v
`timescale 1ns/1ps
`include "fault_selector_defines.vh"

// Notes on behaviour
// (RULE1) Fault when inputs differ over 6.25%
// (RULE2) Fault with larger inactive input swaps
// (RULE3) During fault, larger input feeds calculations
// (RULE4) Phase input selected after reset
// (RULE5) Fault recognised about one second later
// (RULE6) Detection off below 0.3% full scale
// (RULE7) Selected input shown in accumulation bit 7
// (RULE8) Calibration bits 5:4 force input select
// (RULE9) Flag set on fault entry and exit
// (RULE10) Enabled flag raises the interrupt
// (RULE11) Neutral below 93.75% flags, no swap
// (RULE12) Flag follows fault about three seconds; the code flags neutral low at fault entry, after about one second
// (RULE13) Neutral exceeds phase: flag and swap
// (RULE14) Return to phase needs 6.25% margin
// (RULE15) Sign control flags phase within 6.25%
// (RULE16) Neutral gain trim, signed 12 bits
// (RULE17) Software computes trim from forced measurements
// (RULE18) Flag held until software clears it
module current_input_fault_selector #(
  parameter [31:0] FAULT_QUAL_COUNT = `FAULT_QUAL_CYCLES,
  parameter [31:0] SWAP_QUAL_COUNT = `SWAP_QUAL_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire [`ADDR_WIDTH-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire sample_valid,
  input wire signed [`SAMPLE_W-1:0] phase_current_input,
  input wire signed [`SAMPLE_W-1:0] neutral_current_input,
  output reg signed [`SAMPLE_W-1:0] selected_current,
  output reg selected_valid,
  output reg selected_input_indicator,
  output reg irq
);
  reg [7:0] accumulation_mode_reg;
  reg [7:0] calibration_mode_reg;
  reg [`TRIM_W-1:0] neutral_input_gain_trim;
  reg [7:0] interrupt_enable_one;
  reg fault_change_flag;
  reg sel_reg;
  reg sel_next;
  reg fault_state_reg;
  reg flag_set;
  reg bus_done_reg;
  reg [31:0] rdata_next;
  wire [`MAG_W-1:0] phase_level;
  wire [`MAG_W-1:0] neutral_raw_level;
  wire [`MAG_W-1:0] neutral_level;
  wire signed [`SAMPLE_W-1:0] neutral_trimmed;
  wire [1:0] forced_input_select;
  wire sign_ctrl;
  wire active_phase;
  wire detect_enable;
  wire fault_now;
  wire neutral_low;
  wire neutral_high;
  wire phase_high;
  wire phase_close;
  wire fault_qual;
  wire low_qual;
  wire swap_up_qual;
  wire swap_back_qual;
  wire close_qual;
  wire word_read;
  wire word_write;
  wire [7:0] reg_index;
  wire [33:0] phase_scaled;
  wire [33:0] neutral_scaled;
  wire [33:0] floor_scaled;

  // Scale a level by 16 or by 15, so compares test against 15/16, the 6.25% margin
  function [`MAG_W+3:0] times_sixteen;
    input [`MAG_W-1:0] v;
    begin
      times_sixteen = {v, 4'h0};
    end
  endfunction

  function [`MAG_W+3:0] times_fifteen;
    input [`MAG_W-1:0] v;
    begin
      times_fifteen = {v, 4'h0} - {4'h0, v};
    end
  endfunction

  // Gain trim applied ahead of averaging; resolution 2^-12 per step
  function signed [`SAMPLE_W-1:0] apply_trim;
    input signed [`SAMPLE_W-1:0] s;
    input signed [`TRIM_W-1:0] t;
    reg signed [`SAMPLE_W+`TRIM_W:0] prod;
    begin
      prod = s * t;
      apply_trim = s + prod[`SAMPLE_W+11:12];
    end
  endfunction

  assign forced_input_select = calibration_mode_reg[`BIT_FORCE_HI:`BIT_FORCE_LO];
  assign sign_ctrl = accumulation_mode_reg[`BIT_SIGN_CTRL];
  assign active_phase = ~sel_reg;
  // (RULE16) Neutral trim applied
  assign neutral_trimmed = apply_trim(neutral_current_input, neutral_input_gain_trim);
  assign reg_index = avs_address[9:2];
  assign word_read = avs_read & ~bus_done_reg;
  // Write lands on the edge where the master sees waitrequest low
  assign word_write = avs_write & bus_done_reg;

  magnitude_averager phase_avg (
    .clock(clock),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(phase_current_input),
    .level(phase_level)
  );

  magnitude_averager neutral_avg (
    .clock(clock),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(neutral_trimmed),
    .level(neutral_raw_level)
  );
  assign neutral_level = neutral_raw_level;

  // (RULE6) Light-load inhibit
  // Wide products, a maximum 23-bit level times 1000 overflows 32 bits
  assign phase_scaled = {11'h000, phase_level} * `LIGHT_LOAD_DEN;
  assign neutral_scaled = {11'h000, neutral_level} * `LIGHT_LOAD_DEN;
  assign floor_scaled = {10'h000, `FULL_SCALE_CODE} * `LIGHT_LOAD_NUM;
  assign detect_enable = (phase_scaled > floor_scaled) | (neutral_scaled > floor_scaled);

  // (RULE11) Neutral under 15/16 of phase
  assign neutral_low = times_sixteen(neutral_level) < times_fifteen(phase_level);
  // (RULE13) Neutral minus phase over 1/16 neutral
  assign neutral_high = times_fifteen(neutral_level) > times_sixteen(phase_level);
  // (RULE14) Phase minus neutral over 1/16 neutral
  assign phase_high = times_sixteen(phase_level) > {1'b0, neutral_level, 4'h0} +
                      {4'h0, neutral_level};
  // (RULE15) Phase within 1/16 of neutral
  assign phase_close = ~neutral_high & ~phase_high & ~neutral_low;
  // (RULE1) Difference beyond 6.25% of active level
  assign fault_now = detect_enable &
                     (active_phase ? (neutral_low | neutral_high) : (phase_high | neutral_low));

  // (RULE5) One-second qualify
  qualify_timer #(.COUNT(FAULT_QUAL_COUNT)) fault_timer (
    .clock(clock),
    .rst_n(rst_n),
    .condition(fault_now),
    .qualified(fault_qual)
  );

  // (RULE12) Three-second flag delay
  qualify_timer #(.COUNT(SWAP_QUAL_COUNT)) low_timer (
    .clock(clock),
    .rst_n(rst_n),
    .condition(detect_enable & active_phase & neutral_low),
    .qualified(low_qual)
  );

  qualify_timer #(.COUNT(SWAP_QUAL_COUNT)) up_timer (
    .clock(clock),
    .rst_n(rst_n),
    .condition(detect_enable & active_phase & neutral_high),
    .qualified(swap_up_qual)
  );

  qualify_timer #(.COUNT(SWAP_QUAL_COUNT)) back_timer (
    .clock(clock),
    .rst_n(rst_n),
    .condition(detect_enable & ~active_phase & phase_high),
    .qualified(swap_back_qual)
  );

  qualify_timer #(.COUNT(SWAP_QUAL_COUNT)) close_timer (
    .clock(clock),
    .rst_n(rst_n),
    .condition(detect_enable & phase_close),
    .qualified(close_qual)
  );

  always @* begin
    sel_next = sel_reg;
    case (forced_input_select)
      // (RULE8) Forced selection
      `FORCE_PHASE: sel_next = 1'b0;
      `FORCE_NEUTRAL: sel_next = 1'b1;
      default: begin
        // (RULE2) Automatic swap to larger
        if (active_phase && swap_up_qual) begin
          sel_next = 1'b1;
        end else if (!active_phase && swap_back_qual) begin
          sel_next = 1'b0;
        end
      end
    endcase
  end

  always @* begin
    flag_set = 1'b0;
    if (!sign_ctrl) begin
      // (RULE9) Entry and exit both flag
      if (fault_qual != fault_state_reg) begin
        flag_set = 1'b1;
      end
      // (RULE11) Flag without swap
      if (low_qual && !fault_state_reg) begin
        flag_set = 1'b1;
      end
      // (RULE13) Flag with swap
      if (active_phase && swap_up_qual) begin
        flag_set = 1'b1;
      end
    end else begin
      // (RULE15) Early flag on closeness
      if (close_qual) begin
        flag_set = 1'b1;
      end
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (reg_index)
      `IDX_ACCUMULATION_MODE_REG: rdata_next = {24'h000000, sel_reg, accumulation_mode_reg[6:0]};
      `IDX_GAIN_TRIM: rdata_next = {20'h00000, neutral_input_gain_trim};
      `IDX_CALIBRATION_MODE_REG: rdata_next = {24'h000000, calibration_mode_reg};
      `IDX_IRQ_EN1: rdata_next = {24'h000000, interrupt_enable_one};
      `IDX_IRQ_ST1: rdata_next = {26'h0000000, fault_change_flag, 5'h00};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      accumulation_mode_reg <= `ACCUMULATION_MODE_REG_RESET;
      calibration_mode_reg <= `CALIBRATION_MODE_REG_RESET;
      neutral_input_gain_trim <= `GAIN_TRIM_RESET;
      interrupt_enable_one <= 8'h00;
      fault_change_flag <= 1'b0;
      // (RULE4) Phase after reset
      sel_reg <= 1'b0;
      fault_state_reg <= 1'b0;
      bus_done_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      selected_current <= {`SAMPLE_W{1'b0}};
      selected_valid <= 1'b0;
      selected_input_indicator <= 1'b0;
      irq <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      fault_state_reg <= fault_qual;
      // Fixed one-wait answer: waitrequest drops one cycle after request
      bus_done_reg <= (avs_read | avs_write) & ~bus_done_reg;
      avs_waitrequest <= ~((avs_read | avs_write) & ~bus_done_reg);
      if (word_read) begin
        avs_readdata <= rdata_next;
      end
      if (word_write && avs_byteenable[0]) begin
        case (reg_index)
          // Bit 7 is status only, never written
          `IDX_ACCUMULATION_MODE_REG: accumulation_mode_reg <= {1'b0, avs_writedata[6:0]};
          `IDX_CALIBRATION_MODE_REG: calibration_mode_reg <= avs_writedata[7:0];
          `IDX_IRQ_EN1: interrupt_enable_one <= avs_writedata[7:0];
          default: begin
          end
        endcase
      end
      if (word_write && reg_index == `IDX_GAIN_TRIM) begin
        if (avs_byteenable[0]) begin
          neutral_input_gain_trim[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          neutral_input_gain_trim[11:8] <= avs_writedata[11:8];
        end
      end
      // (RULE18) Sticky flag, set beats clear
      if (flag_set) begin
        fault_change_flag <= 1'b1;
      end else if (word_write && avs_byteenable[0] && reg_index == `IDX_IRQ_ST1 &&
                   avs_writedata[`BIT_FAULT_FLAG]) begin
        fault_change_flag <= 1'b0;
      end
      // (RULE10) Enabled flag drives interrupt
      irq <= fault_change_flag & interrupt_enable_one[`BIT_FAULT_FLAG];
      // (RULE3) Feed the selected input
      selected_current <= sel_reg ? neutral_trimmed : phase_current_input;
      selected_valid <= sample_valid;
      // (RULE7) Indicator mirrors selection
      selected_input_indicator <= sel_reg;
    end
  end
endmodule

// ===== fault_selector_defines.vh
`ifndef FAULT_SELECTOR_DEFINES_VH
`define FAULT_SELECTOR_DEFINES_VH

// Register word indices, matched against byte address bits 9:2 (printed offsets are not all multiples of four)
`define IDX_ACCUMULATION_MODE_REG 8'h0F
`define IDX_GAIN_TRIM 8'h1C
`define IDX_CALIBRATION_MODE_REG 8'h3D
`define IDX_IRQ_EN1 8'hD9
`define IDX_IRQ_ST1 8'hDC
`define ADDR_WIDTH 10
// Field positions
`define BIT_SEL_IND 7
`define BIT_SIGN_CTRL 6
`define BIT_FAULT_FLAG 5
`define BIT_FORCE_LO 4
`define BIT_FORCE_HI 5
// Force field codes
`define FORCE_PHASE 2'h1
`define FORCE_NEUTRAL 2'h2
// Reset values
`define ACCUMULATION_MODE_REG_RESET 8'h00
`define CALIBRATION_MODE_REG_RESET 8'h00
`define GAIN_TRIM_RESET 12'h000
// Sample and accumulator widths
`define SAMPLE_W 24
`define MAG_W 23
`define TRIM_W 12
// Averaging: magnitude shifts into a leaky average, time constant 2^AVG_SHIFT samples
`define AVG_SHIFT 5'h0C
// Decision window timing, in milliseconds
`define FAULT_QUAL_MS 1000
`define SWAP_QUAL_MS 3000
`define CLOCK_KHZ 20000
`define FAULT_QUAL_CYCLES (`FAULT_QUAL_MS * `CLOCK_KHZ)
`define SWAP_QUAL_CYCLES (`SWAP_QUAL_MS * `CLOCK_KHZ)
// Light load floor: 0.3 percent of full scale code 0x20C49B
`define FULL_SCALE_CODE 24'h20C49B
`define LIGHT_LOAD_NUM 3
`define LIGHT_LOAD_DEN 1000

`endif

// ===== magnitude_averager.v
`timescale 1ns/1ps
`include "fault_selector_defines.vh"

module magnitude_averager (
  input wire clock,
  input wire rst_n,
  input wire sample_valid,
  input wire signed [`SAMPLE_W-1:0] sample,
  output reg [`MAG_W-1:0] level
);
  reg [`MAG_W+11:0] acc_reg;
  reg [`MAG_W+11:0] acc_next;
  reg [`MAG_W-1:0] mag;

  always @* begin
    mag = sample[`SAMPLE_W-1] ? (~sample[`MAG_W-1:0] + {{(`MAG_W-1){1'b0}}, 1'b1})
                              : sample[`MAG_W-1:0];
    acc_next = acc_reg - (acc_reg >> `AVG_SHIFT) + {12'h000, mag};
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      acc_reg <= {(`MAG_W+12){1'b0}};
      level <= {`MAG_W{1'b0}};
    end else begin
      if (sample_valid) begin
        acc_reg <= acc_next;
      end
      level <= acc_reg[`MAG_W+11:12];
    end
  end
endmodule

// ===== qualify_timer.v
`timescale 1ns/1ps

module qualify_timer #(
  parameter [31:0] COUNT = 32'h0000_0001
) (
  input wire clock,
  input wire rst_n,
  input wire condition,
  output reg qualified
);
  // Restarts whenever the condition drops, so short glitches never qualify
  reg [31:0] count_reg;

  always @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= 32'h0000_0000;
      qualified <= 1'b0;
    end else if (!condition) begin
      count_reg <= 32'h0000_0000;
      qualified <= 1'b0;
    end else if (count_reg >= COUNT - 32'h0000_0001) begin
      qualified <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end
endmodule

// ===== cifs_props.sv
`timescale 1ns/1ps
module cifs_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic signed [23:0] phase_current_input,
  input wire logic signed [23:0] selected_current,
  input wire logic selected_valid,
  input wire logic selected_input_indicator,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  reg [1:0] since_wr;
  // Age of last accepted write, saturates at 3
  always @(posedge clock) begin
    if (!rst_n) begin
      since_wr <= 2'h3;
    end else if (avs_write && !avs_waitrequest) begin
      since_wr <= 2'h0;
    end else if (since_wr != 2'h3) begin
      since_wr <= since_wr + 2'h1;
    end
  end
  sequence req_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence wr_cal(logic [1:0] code);
    avs_write && !avs_waitrequest && avs_address == 10'h0F4 && avs_byteenable[0]
      && avs_writedata[5:4] == code;
  endsequence
  chk_wait_one:
    assert property (req_start |=> !avs_waitrequest) else $error("no answer after one wait");
  chk_wait_single:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  chk_irq_hold:
    assert property ($fell(irq) |-> since_wr != 2'h3) else $error("irq dropped by itself");
  chk_valid_pipe:
    assert property (sample_valid |=> selected_valid) else $error("selected sample missing");
  chk_force_neutral:
    assert property (wr_cal(2'h2) |-> ##[1:3] selected_input_indicator)
      else $error("force neutral ignored");
  chk_force_phase:
    assert property (wr_cal(2'h1) |-> ##[1:3] !selected_input_indicator)
      else $error("force phase ignored");
  chk_phase_data:
    assert property (selected_valid && !selected_input_indicator
      && $past(selected_input_indicator) == 1'b0
      |-> selected_current == $past(phase_current_input)) else $error("phase sample wrong");
  chk_reset_phase:
    assert property ($rose(rst_n) |-> !selected_input_indicator [*4])
      else $error("not on phase after reset");
endmodule

// ===== adc_source.sv
`timescale 1ns/1ps
module adc_source (
  input wire clock,
  input wire rst_n,
  input wire signed [23:0] amp_p,
  input wire signed [23:0] amp_n,
  output reg sample_valid = 1'b0,
  output reg signed [23:0] phase = 24'h000000,
  output reg signed [23:0] neutral = 24'h000000
);
  reg pol = 1'b0;
  // Alternating sign keeps magnitude at the amplitude
  always @(posedge clock) begin
    sample_valid <= rst_n && !sample_valid;
    if (rst_n && !sample_valid) begin
      pol <= !pol;
      phase <= pol ? -amp_p : amp_p;
      neutral <= pol ? -amp_n : amp_n;
    end else begin
      // Junk between samples, never a stale copy
      phase <= ~phase;
      neutral <= ~neutral;
    end
  end
endmodule

// ===== current_input_fault_selector_tb_top.sv
`timescale 1ns/1ps
module current_input_fault_selector_tb_top;
  reg clock;
  reg rst_n = 1'b0;
  reg [9:0] avs_address = 10'h000;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sample_valid, selected_valid, selected_input_indicator, irq;
  wire signed [23:0] phase_in, neutral_in, selected_current;
  reg signed [23:0] amp_p = 24'h080000;
  reg signed [23:0] amp_n = 24'h040000;
  reg model_sel = 1'b0;
  reg mon_on = 1'b0;
  reg [31:0] q, r;
  integer i;
  integer fail_count = 0;
  integer check_count = 0;
  reg signed [23:0] exp_q[$];
  localparam logic [9:0] ADDRS [6] = '{10'h03C, 10'h070, 10'h0F4, 10'h364, 10'h370, 10'h3FC};
  adc_source src_u (.clock(clock), .rst_n(rst_n), .amp_p(amp_p), .amp_n(amp_n),
    .sample_valid(sample_valid), .phase(phase_in), .neutral(neutral_in));
  current_input_fault_selector #(.FAULT_QUAL_COUNT(32'h10), .SWAP_QUAL_COUNT(32'h30)) dut_u (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .phase_current_input(phase_in),
    .neutral_current_input(neutral_in), .selected_current(selected_current),
    .selected_valid(selected_valid), .selected_input_indicator(selected_input_indicator),
    .irq(irq));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] seen, input [31:0] expv);
    begin
      check_count = check_count + 1;
      if (seen !== expv) begin
        $display("ERROR %s expected %h seen %h", nm, expv, seen);
        fail_count = fail_count + 1;
      end
    end
  endtask
  task bus(input w, input [9:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 20) begin
        fail_count = fail_count + 1;
        close_out;
      end
    end
  endtask
  task wait_on(input sel_irq, input v);
    integer n;
    begin
      n = 0;
      while ((sel_irq ? irq : selected_input_indicator) !== v && n < 60000) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n == 60000) begin
        fail_count = fail_count + 1;
        close_out;
      end
    end
  endtask
  task settle(input sel);
    begin
      model_sel = sel;
      repeat (4) @(posedge clock);
      mon_on = 1'b1;
    end
  endtask
  // Model: selected sample of each input pulse
  always @(posedge clock) begin
    if (selected_valid === 1'b1 && exp_q.size() > 0) begin
      if (mon_on)
        check("selected_current", selected_current, exp_q[0]);
      void'(exp_q.pop_front());
    end
    if (sample_valid === 1'b1)
      exp_q.push_back(model_sel ? neutral_in : phase_in);
  end
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    void'($urandom(32'h31EF));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b0, ADDRS[i], 32'h0);
      check("reset read", q, 32'h0);
    end
    mon_on = 1'b1;
    bus(1'b1, 10'h364, 32'h20);
    wait_on(1'b1, 1'b1);
    bus(1'b0, 10'h370, 32'h0);
    check("status", q & 32'h20, 32'h20);
    check("indicator", selected_input_indicator, 1'b0);
    bus(1'b0, 10'h370, 32'h0);
    check("status kept", q & 32'h20, 32'h20);
    bus(1'b1, 10'h370, 32'h20);
    repeat (3) @(posedge clock);
    check("irq", irq, 1'b0);
    $display("neutral low test done");
    mon_on = 1'b0;
    amp_p <= 24'h040000;
    amp_n <= 24'h080000;
    wait_on(1'b0, 1'b1);
    settle(1'b1);
    bus(1'b0, 10'h370, 32'h0);
    check("status", q & 32'h20, 32'h20);
    check("irq", irq, 1'b1);
    bus(1'b0, 10'h03C, 32'h0);
    check("indicator bit", q & 32'h80, 32'h80);
    repeat (40) @(posedge clock);
    bus(1'b1, 10'h370, 32'h20);
    $display("swap test done");
    mon_on = 1'b0;
    amp_p <= 24'h080000;
    amp_n <= 24'h040000;
    wait_on(1'b0, 1'b0);
    settle(1'b0);
    bus(1'b0, 10'h370, 32'h0);
    check("status", q & 32'h20, 32'h20);
    bus(1'b1, 10'h370, 32'h20);
    $display("return test done");
    mon_on = 1'b0;
    // Codes 1, 2, 3, 0; only 2 puts neutral in use
    for (i = 1; i < 5; i = i + 1) begin
      bus(1'b1, 10'h0F4, (i % 4) << 4);
      // Automatic codes return to phase only after the swap-back qualify time
      if (i % 4 == 1 || i % 4 == 2)
        repeat (4) @(posedge clock);
      else
        wait_on(1'b0, 1'b0);
      @(posedge clock);
      check("forced", selected_input_indicator, i == 2);
      bus(1'b0, 10'h0F4, 32'h0);
      check("calibration", q, (i % 4) << 4);
    end
    $display("force test done");
    r = $urandom;
    bus(1'b1, 10'h070, r);
    bus(1'b0, 10'h070, 32'h0);
    check("trim", q, r & 32'hFFF);
    bus(1'b1, 10'h03C, 32'h80);
    bus(1'b0, 10'h03C, 32'h0);
    check("indicator bit", q & 32'h80, 32'h0);
    bus(1'b1, 10'h3FC, r);
    bus(1'b0, 10'h3FC, 32'h0);
    check("unmapped", q, 32'h0);
    $display("register test done");
    close_out;
  end
endmodule
bind current_input_fault_selector cifs_props chk_u (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
  .phase_current_input(phase_current_input), .selected_current(selected_current),
  .selected_valid(selected_valid), .selected_input_indicator(selected_input_indicator),
  .irq(irq));
